/* fsk_modem.sv */
// low-speed fsk modem: tone synthesiser and edge-timing demodulator
`timescale 1ns/1ps
`default_nettype none

// Contract
// R1: standard select high picks US tones, low picks CCITT, both directions.
// R2: transmit bit high is mark, low is space, in both standards.
// R3: carrier synthesised from a 1.0 MHz reference tick.
// R4: US: originate 1270/1070 Hz, answer 2225/2025 Hz mark/space.
// R5: CCITT: channel one 980/1180 Hz, channel two 1650/1850 Hz mark/space.
// R6: echo high, CCITT, mode low, bit high sends 2100 Hz tone.
// R7: other side holds echo low during normal data.
// R8: carrier output silent whenever transmit enable is low.
// R9: mode high picks originate or channel one, low answer or channel two.
// R10: receive output carries data demodulated from the incoming carrier.
// R11: line side feeds a limited square wave at 50% +/- 2% duty.
// R12: rate input high tunes for up to 300 bps, low for 600.
// R13: loopback test makes demodulator listen to its own transmit tones.
// R14: demodulator reset input high disables the demodulator.
// R15: demodulator reset never forces the receive output.
// R16: demodulator listens to the complementary pair unless loopback test.
// R17: receive output high for mark, low for space.
module fsk_modem
  import fsk_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       ce,
  input  wire fsk_pins_t  pins,
  input  wire logic       rx_car,
  output logic [7:0]      tx_car,
  output logic            tx_active,
  output logic            rx_data
);

  // pin synchronisers: three stages, change accepted when stages two and three agree
  logic [8:0]        sync1;
  logic [8:0]        sync2;
  logic [8:0]        sync3;
  logic [8:0]        stab;
  wire  [8:0]        raw = {pins, rx_car};
  wire  [8:0]        agree = ~(sync2 ^ sync3);
  wire  [8:0]        next_stab = (sync2 & agree) | (stab & ~agree);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      sync1 <= SYNC_RST;
      sync2 <= SYNC_RST;
      sync3 <= SYNC_RST;
      stab  <= SYNC_RST;
    end else if (ce) begin
      sync1 <= raw;
      sync2 <= sync1;
      sync3 <= sync2;
      stab  <= next_stab; // R11
    end
  end

  fsk_pins_t         p;
  wire               rx_pin = stab[0];
  assign p = fsk_pins_t'(stab[8:1]);

  // reference tick at 1 MHz from the system clock
  logic [6:0]        div_cnt;
  logic              tick;
  wire               div_wrap = (div_cnt == REF_LAST);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      div_cnt <= 7'h00;
      tick    <= 1'b0;
    end else if (ce) begin
      div_cnt <= div_wrap ? 7'h00 : div_cnt + 7'h01; // R3
      tick    <= div_wrap;
    end
  end

  // transmit tone selection
  wire               echo_tone = p.echo & ~p.us_std & ~p.mode & p.tx_data; // R6
  wire [PHASE_W-1:0] us_inc = p.mode ? (p.tx_data ? INC_US_OM : INC_US_OS)
                                     : (p.tx_data ? INC_US_AM : INC_US_AS); // R4 R9 R2
  wire [PHASE_W-1:0] cc_inc = p.mode ? (p.tx_data ? INC_CC_1M : INC_CC_1S)
                                     : (p.tx_data ? INC_CC_2M : INC_CC_2S); // R5 R9 R2
  wire [PHASE_W-1:0] tx_inc = echo_tone ? INC_ECHO : (p.us_std ? us_inc : cc_inc); // R1

  logic [PHASE_W-1:0] phase;

  // phase restarts at zero so each burst begins at midscale
  always_ff @(posedge clk) begin
    if (!nrst) begin
      phase <= '0;
    end else if (ce) begin
      if (!p.tx_enable) begin
        phase <= '0; // R8
      end else if (tick) begin
        phase <= phase + tx_inc; // R3
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      tx_car    <= CAR_MID;
      tx_active <= 1'b0;
    end else if (ce) begin
      tx_car    <= p.tx_enable ? fsk_sine(phase[PHASE_W-1 -: 4]) : CAR_MID; // R8
      tx_active <= p.tx_enable;
    end
  end

  // receive pair and input selection
  wire               recv_orig = p.loopback_test ? p.mode : ~p.mode; // R13 R16
  wire               rx_in = p.loopback_test ? phase[PHASE_W-1] : rx_pin; // R13
  wire [HALF_W-1:0]  thr = p.us_std ? (recv_orig ? THR_US_ORIG : THR_US_ANS)
                                    : (recv_orig ? THR_CC_CH1 : THR_CC_CH2); // R1

  logic              rx_prev;
  logic [HALF_W-1:0] halfcnt;
  logic              cand;
  logic [2:0]        run;

  wire               half_done = rx_in ^ rx_prev;
  wire               is_high = (halfcnt < thr);
  // us marks are the upper tone, ccitt marks the lower
  wire               mark = ~(is_high ^ p.us_std); // R17
  wire [2:0]         need = p.rx_rate_300 ? RX_AGREE_300 : RX_AGREE_600; // R12
  wire [2:0]         next_run = (mark == cand) ? ((run == RUN_MAX) ? run : run + 3'h1) : 3'h1;
  wire               commit = half_done & (next_run >= need);

  // more agreeing half-cycles at 300 bps trades latency for noise immunity
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rx_prev <= 1'b0;
      halfcnt <= '0;
      cand    <= RX_IDLE;
      run     <= 3'h0;
    end else if (ce) begin
      rx_prev <= rx_in;
      if (p.demod_reset) begin
        halfcnt <= '0; // R14
        cand    <= RX_IDLE;
        run     <= 3'h0;
      end else if (half_done) begin
        halfcnt <= '0;
        cand    <= mark;
        run     <= next_run;
      end else if (tick && halfcnt != HALF_MAX) begin
        halfcnt <= halfcnt + 10'h001;
      end
    end
  end

  // output held while the demodulator is disabled, never forced by it
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rx_data <= RX_IDLE;
    end else if (ce && !p.demod_reset && commit) begin
      rx_data <= mark; // R10 R15 R17
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  sequence s_ref_tick;
    ce && tick;
  endsequence

  sequence s_next_live;
    ##1 ce;
  endsequence

  a_ref_tick_gap: assert property ( // R3
    s_ref_tick ##0 s_next_live |-> !tick)
    else $error("reference tick repeated on adjacent cycles");

  a_phase_step: assert property ( // R3
    (ce && tick && p.tx_enable) |=> phase == $past(phase) + $past(tx_inc))
    else $error("phase did not advance by the tone step");

  a_us_orig_mark: assert property ( // R4
    (p.us_std && !p.echo && p.mode && p.tx_data) |-> tx_inc == INC_US_OM)
    else $error("wrong us originate mark step");

  a_us_answer_space: assert property ( // R2
    (p.us_std && !p.mode && !p.tx_data) |-> tx_inc == INC_US_AS)
    else $error("wrong us answer space step");

  a_ccitt_ch2_space: assert property ( // R5
    (!p.us_std && !p.mode && !p.tx_data) |-> tx_inc == INC_CC_2S)
    else $error("wrong ccitt channel two space step");

  a_ccitt_ch1_mark: assert property ( // R9
    (!p.us_std && p.mode && p.tx_data) |-> tx_inc == INC_CC_1M)
    else $error("wrong ccitt channel one mark step");

  a_echo_tone_sel: assert property ( // R6
    (p.echo && !p.us_std && !p.mode && p.tx_data) |-> tx_inc == INC_ECHO)
    else $error("echo disable tone not selected");

  a_car_silent: assert property ( // R8
    (ce && !p.tx_enable) |=> (tx_car == CAR_MID && !tx_active && phase == '0))
    else $error("carrier active while transmit disabled");

  a_rx_pair_sel: assert property ( // R16
    p.loopback_test ? (recv_orig == p.mode) : (recv_orig != p.mode))
    else $error("demodulator listening to wrong tone pair");

  a_loop_source: assert property ( // R13
    p.loopback_test |-> rx_in == phase[PHASE_W-1])
    else $error("loopback not fed from own carrier");

  a_demod_hold: assert property ( // R14
    (ce && p.demod_reset) |=> ($stable(rx_data) && halfcnt == '0))
    else $error("demodulator active or output moved under demod reset");

  a_rx_commit: assert property ( // R17
    (ce && !p.demod_reset && commit) |=> rx_data == $past(mark))
    else $error("receive output did not follow decided bit");

  a_rate_filter: assert property ( // R12
    (ce && half_done && !p.demod_reset && next_run < need) |=> $stable(rx_data))
    else $error("receive output changed before enough agreeing half-cycles");

  sequence s_demod_live;
    ce && !p.demod_reset;
  endsequence

  a_us_orig_space: assert property ( // R4
    (p.us_std && p.mode && !p.tx_data) |-> tx_inc == INC_US_OS)
    else $error("wrong us originate space step");

  a_us_answer_mark: assert property ( // R4
    (p.us_std && !p.mode && p.tx_data) |-> tx_inc == INC_US_AM)
    else $error("wrong us answer mark step");

  a_ccitt_ch1_space: assert property ( // R5
    (!p.us_std && p.mode && !p.tx_data) |-> tx_inc == INC_CC_1S)
    else $error("wrong ccitt channel one space step");

  a_ccitt_ch2_mark: assert property ( // R5
    (!p.us_std && !p.echo && !p.mode && p.tx_data) |-> tx_inc == INC_CC_2M)
    else $error("wrong ccitt channel two mark step");

  a_echo_us_plain: assert property ( // R6
    (p.echo && p.us_std && !p.mode && p.tx_data) |-> tx_inc == INC_US_AM)
    else $error("echo input changed a us tone");

  a_echo_space_plain: assert property ( // R6
    (p.echo && !p.us_std && !p.mode && !p.tx_data) |-> tx_inc == INC_CC_2S)
    else $error("echo input changed a space tone");

  a_active_follow: assert property ( // R8
    ce |=> tx_active == $past(p.tx_enable))
    else $error("carrier active flag does not follow transmit enable");

  a_car_peak: assert property ( // R3
    (ce && p.tx_enable && phase[PHASE_W-1 -: 4] == 4'h4) |=> tx_car == 8'hff)
    else $error("carrier missed its positive peak at quarter turn");

  a_tick_align: assert property ( // R3
    (ce && div_wrap) |=> (tick && div_cnt == 7'h00))
    else $error("reference tick not raised on divider wrap");

  a_div_range: assert property ( // R3
    div_cnt <= REF_LAST)
    else $error("reference divider out of range");

  a_phase_idle: assert property ( // R3
    (ce && p.tx_enable && !tick) |=> $stable(phase))
    else $error("phase moved between reference ticks");

  a_rx_sync: assert property ( // R10
    (ce && sync2[0] == sync3[0]) |=> stab[0] == $past(sync2[0]))
    else $error("agreed receive carrier level not taken");

  a_rx_glitch: assert property ( // R10
    (ce && sync2[0] != sync3[0]) |=> stab[0] == $past(stab[0]))
    else $error("unsettled receive carrier level taken");

  a_pin_source: assert property ( // R10
    !p.loopback_test |-> rx_in == rx_pin)
    else $error("demodulator not fed from the receive pin");

  a_half_restart: assert property ( // R10
    s_demod_live ##0 half_done |=> halfcnt == '0)
    else $error("half-period count not restarted on carrier edge");

  a_half_count: assert property ( // R10
    s_demod_live ##0 (!half_done && tick && halfcnt != HALF_MAX) |=> halfcnt == $past(halfcnt) + 10'h001)
    else $error("half-period count missed a reference tick");

  a_run_clear: assert property ( // R14
    (ce && p.demod_reset) |=> (run == 3'h0 && cand == RX_IDLE))
    else $error("agreement run not cleared under demod reset");

  a_rx_steady: assert property ( // R15
    (ce && !commit) |=> $stable(rx_data))
    else $error("receive output moved without a decided bit");

  a_thr_us_answer: assert property ( // R16
    (p.us_std && !p.loopback_test && p.mode) |-> thr == THR_US_ANS)
    else $error("originate side not listening to answer tones");

  a_thr_cc_ch1: assert property ( // R16
    (!p.us_std && !p.loopback_test && !p.mode) |-> thr == THR_CC_CH1)
    else $error("channel two side not listening to channel one tones");

  a_thr_loop_orig: assert property ( // R13
    (p.us_std && p.loopback_test && p.mode) |-> thr == THR_US_ORIG)
    else $error("loopback not tuned to own originate tones");

  a_mark_ccitt: assert property ( // R17
    (!p.us_std && half_done && thr == THR_CC_CH1 && halfcnt > THR_CC_CH1) |-> mark)
    else $error("ccitt lower tone not read as mark");

  a_mark_us: assert property ( // R17
    (p.us_std && half_done && thr == THR_US_ANS && halfcnt < THR_US_ANS) |-> mark)
    else $error("us upper tone not read as mark");

endmodule : fsk_modem

`default_nettype wire

/* fsk_pkg.sv */
// constants, pin group and helper functions for the low-speed fsk modem
package fsk_pkg;

  localparam int unsigned CLK_HZ   = 100_000_000;
  localparam int unsigned REF_HZ   = 1_000_000;
  localparam int unsigned REF_DIV  = CLK_HZ / REF_HZ;
  localparam logic [6:0]  REF_LAST = 7'(REF_DIV - 1);

  localparam int unsigned PHASE_W  = 24;
  localparam int unsigned HALF_W   = 10;
  localparam longint      ACC_SCALE = 64'h1000000;

  // tone frequencies in hz
  localparam int unsigned F_US_OM  = 1270;
  localparam int unsigned F_US_OS  = 1070;
  localparam int unsigned F_US_AM  = 2225;
  localparam int unsigned F_US_AS  = 2025;
  localparam int unsigned F_CC_1M  = 980;
  localparam int unsigned F_CC_1S  = 1180;
  localparam int unsigned F_CC_2M  = 1650;
  localparam int unsigned F_CC_2S  = 1850;
  localparam int unsigned F_ECHO   = 2100;

  // phase step per reference tick, rounded to nearest
  function automatic logic [PHASE_W-1:0] fsk_inc(input int unsigned f);
    longint t;
    t = (longint'(f) * ACC_SCALE + longint'(REF_HZ / 2)) / longint'(REF_HZ);
    return t[PHASE_W-1:0];
  endfunction : fsk_inc

  // half-period boundary in reference ticks between two tones
  function automatic logic [HALF_W-1:0] fsk_thr(input int unsigned fa, input int unsigned fb);
    int unsigned t;
    t = (REF_HZ / (2 * fa) + REF_HZ / (2 * fb)) / 2;
    return t[HALF_W-1:0];
  endfunction : fsk_thr

  localparam logic [PHASE_W-1:0] INC_US_OM = fsk_inc(F_US_OM);
  localparam logic [PHASE_W-1:0] INC_US_OS = fsk_inc(F_US_OS);
  localparam logic [PHASE_W-1:0] INC_US_AM = fsk_inc(F_US_AM);
  localparam logic [PHASE_W-1:0] INC_US_AS = fsk_inc(F_US_AS);
  localparam logic [PHASE_W-1:0] INC_CC_1M = fsk_inc(F_CC_1M);
  localparam logic [PHASE_W-1:0] INC_CC_1S = fsk_inc(F_CC_1S);
  localparam logic [PHASE_W-1:0] INC_CC_2M = fsk_inc(F_CC_2M);
  localparam logic [PHASE_W-1:0] INC_CC_2S = fsk_inc(F_CC_2S);
  localparam logic [PHASE_W-1:0] INC_ECHO  = fsk_inc(F_ECHO);

  localparam logic [HALF_W-1:0] THR_US_ORIG = fsk_thr(F_US_OM, F_US_OS);
  localparam logic [HALF_W-1:0] THR_US_ANS  = fsk_thr(F_US_AM, F_US_AS);
  localparam logic [HALF_W-1:0] THR_CC_CH1  = fsk_thr(F_CC_1M, F_CC_1S);
  localparam logic [HALF_W-1:0] THR_CC_CH2  = fsk_thr(F_CC_2M, F_CC_2S);
  localparam logic [HALF_W-1:0] HALF_MAX    = 10'h3ff;

  // agreeing half-cycles before the receive output follows
  localparam logic [2:0] RX_AGREE_300 = 3'h4;
  localparam logic [2:0] RX_AGREE_600 = 3'h2;
  localparam logic [2:0] RUN_MAX      = 3'h7;

  localparam logic [7:0] CAR_MID  = 8'h80;
  localparam logic       RX_IDLE  = 1'b1;
  localparam logic [8:0] SYNC_RST = 9'h000;

  typedef struct packed {
    logic us_std;
    logic mode;
    logic echo;
    logic tx_enable;
    logic rx_rate_300;
    logic loopback_test;
    logic demod_reset;
    logic tx_data;
  } fsk_pins_t;

  // 16-step sine staircase, offset binary
  function automatic logic [7:0] fsk_sine(input logic [3:0] ph);
    case (ph)
      4'h0: return 8'h80;
      4'h1: return 8'hb1;
      4'h2: return 8'hda;
      4'h3: return 8'hf5;
      4'h4: return 8'hff;
      4'h5: return 8'hf5;
      4'h6: return 8'hda;
      4'h7: return 8'hb1;
      4'h8: return 8'h80;
      4'h9: return 8'h4f;
      4'ha: return 8'h26;
      4'hb: return 8'h0b;
      4'hc: return 8'h01;
      4'hd: return 8'h0b;
      4'he: return 8'h26;
      default: return 8'h4f;
    endcase
  endfunction : fsk_sine

endpackage : fsk_pkg

/* fsk_line_model.sv */
// line-side model: limited square-wave receive carrier source
`timescale 1ns/1ps
`default_nettype none
module fsk_line_model (
  input  wire logic        clk,
  input  wire logic        run,
  input  wire logic [15:0] half_clk,
  output logic             rx_car
);
  logic [15:0] cnt;

  // equal half-periods, so duty stays at exactly half
  always_ff @(posedge clk) begin
    if (!run) begin
      cnt    <= 16'h0000;
      rx_car <= 1'b0;
    end else if (cnt >= half_clk - 16'h0001) begin
      cnt    <= 16'h0000;
      rx_car <= ~rx_car;
    end else begin
      cnt <= cnt + 16'h0001;
    end
  end
endmodule : fsk_line_model
`default_nettype wire

/* fsk_low_speed_modem_tb.sv */
// self-checking bench for the low-speed fsk modem
`timescale 1ns/1ps
`default_nettype none
module fsk_low_speed_modem_tb;
  import fsk_pkg::*;
  logic        clk;
  logic        nrst;
  fsk_pins_t   pins;
  logic        run;
  logic [15:0] half_clk;
  logic        rx_car;
  logic [7:0]  tx_car;
  logic        tx_active;
  logic        rx_data;
  int          bad_count = 0;
  int          n_tests = 0;

  fsk_modem fsk_modem_inst (.clk(clk), .nrst(nrst), .ce(1'b1), .pins(pins), .rx_car(rx_car),
    .tx_car(tx_car), .tx_active(tx_active), .rx_data(rx_data));
  fsk_line_model fsk_line_model_inst (.clk(clk), .run(run), .half_clk(half_clk), .rx_car(rx_car));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict();
    if (bad_count == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict

  // silent while disabled, then time the first sine step (1/16 period) from carrier start
  // a whole period would cost up to 102k clocks per tone; one step leaves a one-tick window
  task automatic tone(input logic us, input logic md, input logic ec, input logic dt,
                      input int unsigned f);
    int unsigned cnt;
    int unsigned lo;
    pins <= {us, md, ec, 1'b0, 1'b0, 1'b0, 1'b1, ~dt};
    repeat (12) @(posedge clk);
    pins.tx_data <= dt;
    repeat (12) @(posedge clk);
    check(tx_car, 8'h80);
    check(tx_active, 1'b0);
    pins.tx_enable <= 1'b1;
    // ticks to reach 1/16 turn, rounded up; the first tick lags carrier start by under one tick
    lo = ((REF_HZ + 16 * f - 1) / (16 * f) - 1) * REF_DIV + 1;
    cnt = 0;
    do begin
      @(negedge clk);
      cnt++;
    end while (tx_active !== 1'b1 && cnt < 20);
    check(tx_active, 1'b1);
    cnt = 0;
    do begin
      @(negedge clk);
      cnt++;
    end while (tx_car !== 8'hb1 && cnt < 20000);
    check(cnt >= lo && cnt < lo + REF_DIV, 1'b1);
    @(posedge clk);
  endtask : tone

  // originate listens to answer space (2025 hz); then fast mark edges probe loopback,
  // demod disable and the 300 bps agreement count
  task automatic rx_space();
    int cnt;
    pins     <= {1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
    half_clk <= 16'h6073;
    run      <= 1'b1;
    cnt = 0;
    do begin
      @(posedge clk);
      cnt++;
    end while (rx_data !== 1'b0 && cnt < 130000);
    check(rx_data, 1'b0);
    // 10-tick half-periods read as mark; the pin must be ignored in loopback
    pins.loopback_test <= 1'b1;
    half_clk           <= 16'h03e8;
    repeat (3000) @(posedge clk);
    check(rx_data, 1'b0);
    pins.loopback_test <= 1'b0;
    pins.demod_reset   <= 1'b1;
    repeat (3000) @(posedge clk);
    check(rx_data, 1'b0);
    pins.demod_reset <= 1'b0;
    pins.rx_rate_300 <= 1'b1;
    repeat (2500) @(posedge clk);
    check(rx_data, 1'b0);
    repeat (2000) @(posedge clk);
    check(rx_data, 1'b1);
    run <= 1'b0;
  endtask : rx_space

  initial begin
    nrst     = 1'b0;
    pins     = '0;
    run      = 1'b0;
    half_clk = 16'h0000;
    repeat (16) @(posedge clk);
    check(tx_car, 8'h80);
    check(rx_data, 1'b1);
    nrst <= 1'b1;
    tone(1'b1, 1'b1, 1'b0, 1'b1, F_US_OM);
    tone(1'b1, 1'b1, 1'b0, 1'b0, F_US_OS);
    tone(1'b1, 1'b0, 1'b0, 1'b1, F_US_AM);
    tone(1'b1, 1'b0, 1'b0, 1'b0, F_US_AS);
    tone(1'b0, 1'b1, 1'b0, 1'b1, F_CC_1M);
    tone(1'b0, 1'b1, 1'b0, 1'b0, F_CC_1S);
    tone(1'b0, 1'b0, 1'b0, 1'b1, F_CC_2M);
    tone(1'b0, 1'b0, 1'b0, 1'b0, F_CC_2S);
    tone(1'b0, 1'b0, 1'b1, 1'b1, F_ECHO);
    rx_space();
    give_verdict();
  end

  // all tones plus a few receive half-periods stay well below this
  initial begin
    repeat (300000) @(posedge clk);
    bad_count++;
    give_verdict();
  end
endmodule : fsk_low_speed_modem_tb
`default_nettype wire
